// file: hdl/fwx_pkg.sv
// Shared constants for the width and depth expanded FIFO chain
`default_nettype none

package fwx_pkg;

  // Geometry
  localparam int DATA_W = 20;            // Bits per device word
  localparam int LANES  = 2;             // Devices side by side
  localparam int STAGES = 2;             // Devices in series
  localparam int DEPTH  = 16;            // Words per stage memory

  // Ripple and bubble timing in transfer clock cycles
  localparam int FILL_LAST_CYC   = 3;    // Write to own output ready
  localparam int FILL_HOP_CYC    = 4;    // Added per extra stage
  localparam int DRAIN_FIRST_CYC = 2;    // Read to own input ready
  localparam int DRAIN_HOP_CYC   = 3;    // Added per extra stage

  // Pointer delay chains that produce those figures
  localparam int WPTR_DLY = FILL_LAST_CYC - 1;
  localparam int RPTR_DLY = DRAIN_FIRST_CYC - 1;

  // Extra cycles granted before a latency is called late
  localparam int LATE_SLACK = 4;

  // Strap levels driven during master reset
  localparam logic STRAP_FIRST_WORD_FALL_THROUGH = 1'b1;    // Fall-through timing
  localparam logic STRAP_SDR  = 1'b1;    // Single data rate

endpackage

`default_nettype wire

// file: hdl/fwx_link_if.sv
// Link between the expanded FIFO chain and its writer and reader
`default_nettype none

interface fwx_link_if
  import fwx_pkg::*;
#(
  parameter int LANE_N = LANES,
  parameter int WIDTH  = DATA_W
);
  logic [LANE_N*WIDTH-1:0] write_data_bus;          // Concatenated lanes
  logic                    write_en_n;              // Shared write enable
  logic [LANE_N-1:0]       input_ready_n;           // Per lane, low = room
  logic [LANE_N*WIDTH-1:0] read_data_bus;           // Concatenated lanes
  logic                    read_en_n;               // Shared read enable
  logic [LANE_N-1:0]       output_ready_n;          // Per lane, low = word
  logic                    first_word_fall_through; // Strap
  logic                    single_rate_mode;        // Strap

  modport dev (
    input  write_data_bus, write_en_n, read_en_n,
    input  first_word_fall_through, single_rate_mode,
    output input_ready_n, output_ready_n, read_data_bus
  );

  modport host (
    output write_data_bus, write_en_n, read_en_n,
    output first_word_fall_through, single_rate_mode,
    input  input_ready_n, output_ready_n, read_data_bus
  );
endinterface

`default_nettype wire

// file: hdl/fwx_stage_fifo.sv
// One fall-through FIFO stage with delayed pointer views
`default_nettype none

module fwx_stage_fifo
  import fwx_pkg::*;
#(
  parameter int WIDTH       = DATA_W,
  parameter int DEPTH_WORDS = DEPTH
)(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // Mode gate
  input  wire logic             run,
  // Filling side
  input  wire logic             wr_en_n,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  in_rdy_n_q,
  // Draining side
  input  wire logic             rd_en_n,
  output logic [WIDTH-1:0]      rd_data_q,
  output logic                  out_rdy_n_q
);
  localparam int AW = $clog2(DEPTH_WORDS);

  logic [WIDTH-1:0] mem_q [DEPTH_WORDS];   // Word store, no reset
  logic [AW:0]      wptr_q;                // Write pointer
  logic [AW:0]      rptr_q;                // Read pointer
  logic [AW:0]      wdly_q [WPTR_DLY];     // Write pointer as read side sees it
  logic [AW:0]      rdly_q [RPTR_DLY];     // Read pointer as write side sees it

  // Handshakes and occupancy
  wire              push    = !wr_en_n && !in_rdy_n_q;
  wire              pop     = !rd_en_n && !out_rdy_n_q;
  wire [AW:0]       wptr_d  = wptr_q + {{AW{1'b0}}, push};
  wire [AW:0]       fill_d  = wptr_d - rdly_q[RPTR_DLY-1];
  wire              mem_has = rptr_q != wdly_q[WPTR_DLY-1];
  wire              load    = mem_has && (out_rdy_n_q || pop);
  wire              full_d  = fill_d == (AW+1)'(DEPTH_WORDS);

  // Store, written only on an accepted push
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem_q[wptr_q[AW-1:0]] <= wr_data;
  end

  // Pointers, their delayed views and the two ready flags
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wptr_q      <= '0;
      rptr_q      <= '0;
      wdly_q      <= '{default: '0};
      rdly_q      <= '{default: '0};
      in_rdy_n_q  <= 1'b1;
      out_rdy_n_q <= 1'b1;
      rd_data_q   <= '0;
    end
    else
    begin
      wptr_q <= wptr_d;
      // Delay sets the fill and bubble latency; see RULE14 and RULE18
      wdly_q[0] <= wptr_q;
      rdly_q[0] <= rptr_q;
      for (int i = 1; i < WPTR_DLY; i++)
        wdly_q[i] <= wdly_q[i-1];
      for (int i = 1; i < RPTR_DLY; i++)
        rdly_q[i] <= rdly_q[i-1];
      // Room counted with this edge's push, so no overrun; see RULE17
      in_rdy_n_q <= !run || full_d;
      // Word falls through with no read; see RULE12 and RULE13
      if (load)
      begin
        rd_data_q   <= mem_q[rptr_q[AW-1:0]];
        rptr_q      <= rptr_q + 1'b1;
        out_rdy_n_q <= 1'b0;
      end
      // Refill on the pop edge keeps later words delay free; see RULE16
      else if (pop)
        out_rdy_n_q <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// file: hdl/fwx_chain.sv
// Device end: lanes of chained fall-through FIFO stages
`default_nettype none

module fwx_chain
  import fwx_pkg::*;
#(
  parameter int LANE_N      = LANES,
  parameter int STAGE_N     = STAGES,
  parameter int WIDTH       = DATA_W,
  parameter int DEPTH_WORDS = DEPTH
)(
  // Clock and reset; the transfer clock is ref_clk too
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Link to writer and reader
  fwx_link_if.dev   link,
  // Status
  output logic      cfg_ok_q,
  output logic      mode_error_q
);
  logic caught_q;   // Straps already taken

  // Straps taken at the first edge after reset release
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      caught_q     <= 1'b0;
      cfg_ok_q     <= 1'b0;
      mode_error_q <= 1'b0;
    end
    else if (!caught_q)
    begin
      caught_q     <= 1'b1;
      // Chaining needs fall-through at single rate; see RULE10 and RULE11
      cfg_ok_q     <= link.first_word_fall_through && link.single_rate_mode;
      mode_error_q <= !(link.first_word_fall_through && link.single_rate_mode);
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // One chain per lane, each with its own flags; see RULE2
  for (genvar l = 0; l < LANE_N; l++)
  begin : g_lane
    wire [WIDTH-1:0] dat   [STAGE_N];   // Stage output words
    wire             in_n  [STAGE_N];   // Stage input ready, low = room
    wire             out_n [STAGE_N];   // Stage output ready, low = word

    for (genvar s = 0; s < STAGE_N; s++)
    begin : g_stage
      // Head takes the link, others take the stage before; see RULE8
      wire             wen_n = (s == 0) ? link.write_en_n : out_n[(s == 0) ? 0 : s-1];
      wire [WIDTH-1:0] wdat  = (s == 0) ? link.write_data_bus[l*WIDTH +: WIDTH]
                                        : dat[(s == 0) ? 0 : s-1];
      // Upstream read follows downstream room; see RULE20
      wire             ren_n = (s == STAGE_N-1) ? link.read_en_n
                                                : in_n[(s == STAGE_N-1) ? s : s+1];

      // Series stages add their depths, output words too; see RULE9
      // Every stage runs on the same clock; see RULE19
      fwx_stage_fifo #(
        .WIDTH       (WIDTH),
        .DEPTH_WORDS (DEPTH_WORDS)
      ) u_stage (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .run         (cfg_ok_q),
        .wr_en_n     (wen_n),
        .wr_data     (wdat),
        .in_rdy_n_q  (in_n[s]),
        .rd_en_n     (ren_n),
        .rd_data_q   (dat[s]),
        .out_rdy_n_q (out_n[s])
      );
    end

    // Head room and tail word face the link
    assign link.input_ready_n[l]                    = in_n[0];
    assign link.output_ready_n[l]                   = out_n[STAGE_N-1];
    assign link.read_data_bus[l*WIDTH +: WIDTH]     = dat[STAGE_N-1];
  end

endmodule

`default_nettype wire

// file: hdl/fwx_host.sv
// Writer and reader end: shared controls, composite flags, latency watch
//
// How it works
// RULE1 - Tie all devices' control inputs together
// RULE2 - Devices' flags may differ by one cycle
// RULE3 - Standard mode: AND empty flags, AND full flags
// RULE4 - Fall-through mode: OR output ready, OR input ready
// RULE5 - Combine device flags only through gates
// RULE6 - Side-by-side devices share depth, widths may differ
// RULE7 - Wide buses concatenate each device's bus
// RULE8 - Depth chain: outputs feed next inputs directly
// RULE9 - Chain capacity is the sum of stages
// RULE10 - Strap fall-through timing during master reset
// RULE11 - Strap single data rate on every device
// RULE12 - First word ripples down without any read
// RULE13 - Word at outputs drives output ready low
// RULE14 - Fill: (N-1)*4 transfer plus 3 read cycles
// RULE15 - Allow extra fill and drain cycles for skew
// RULE16 - Only the first word sees ripple delay
// RULE17 - Free slot bubbles back, input ready low
// RULE18 - Drain: (N-1)*3 transfer plus 2 write cycles
// RULE19 - Transfer clock is the faster of write/read
// RULE20 - Stage read from next room, write from word
`default_nettype none

module fwx_host
  import fwx_pkg::*;
#(
  parameter int LANE_N      = LANES,
  parameter int STAGE_N     = STAGES,
  parameter int WIDTH       = DATA_W,
  parameter int DEPTH_WORDS = DEPTH,
  parameter bit FIRST_WORD_FALL_THROUGH        = 1'b1,      // Zero reads flags as standard mode
  parameter int SLACK       = LATE_SLACK
)(
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_b,
  // Link to the device chain
  fwx_link_if.host                     link,
  // Upstream writer
  input  wire logic [LANE_N*WIDTH-1:0] up_data,
  input  wire logic                    up_valid,
  output logic                         up_ready_n_q,
  // Downstream reader
  output logic [LANE_N*WIDTH-1:0]      dn_data_q,
  output logic                         dn_valid_q,
  input  wire logic                    dn_ready,
  // Occupancy and latency status
  output logic [$clog2(STAGE_N*(DEPTH_WORDS+1)+1)-1:0] level_q,
  output logic                         fill_late_q,
  output logic                         drain_late_q
);
  // Whole-chain capacity, each stage memory plus its output word
  localparam int CAPACITY = STAGE_N * (DEPTH_WORDS + 1);
  localparam int LVL_W    = $clog2(CAPACITY + 1);

  // Budgets with skew margin on top; see RULE14, RULE18 and RULE15
  localparam int FILL_BUDGET  = (STAGE_N-1)*FILL_HOP_CYC + FILL_LAST_CYC + SLACK;
  localparam int DRAIN_BUDGET = (STAGE_N-1)*DRAIN_HOP_CYC + DRAIN_FIRST_CYC + SLACK;
  localparam int CNT_W        = $clog2(FILL_BUDGET + DRAIN_BUDGET + 2);

  //////////////////////////////////////////////////////////////////////////////
  // Composite flags

  logic room_all;   // Every lane can take a word
  logic word_all;   // Every lane holds a word

  // Lane flags meet only in gates, never wire to wire; see RULE5
  if (FIRST_WORD_FALL_THROUGH)
  begin : g_first_word_fall_through
    // Any lane not ready holds off the whole word; see RULE4
    wire ir_comp_n = |link.input_ready_n;
    wire or_comp_n = |link.output_ready_n;
    assign room_all = !ir_comp_n;
    assign word_all = !or_comp_n;
  end
  else
  begin : g_std
    // Flags read as empty and full; any lane low wins; see RULE3
    wire empty_flag_n = &link.output_ready_n;
    wire full_flag_n  = &link.input_ready_n;
    assign room_all = full_flag_n;
    assign word_all = empty_flag_n;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Handshakes

  logic wen_n_q;    // Shared write enable, also the hold flag
  logic ren_n_q;    // Shared read enable
  logic [LANE_N*WIDTH-1:0] wdat_q;   // Word held for the chain

  // One enable for all lanes keeps them in lockstep; see RULE1
  wire acc     = !wen_n_q && room_all;
  wire pop     = !ren_n_q && word_all;
  wire up_take = up_valid && !up_ready_n_q;
  wire dn_take = dn_valid_q && dn_ready;

  // Hold register: one word, so the writer sees half rate at best
  wire hold_d  = up_take || (!wen_n_q && !acc);
  wire dnv_d   = pop || (dn_valid_q && !dn_take);

  // Occupancy moves with accepted pushes and pops
  wire [LVL_W-1:0] level_d = level_q + {{(LVL_W-1){1'b0}}, acc}
                                     - {{(LVL_W-1){1'b0}}, pop};

  // Write side: hold, shared enable and writer ready
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wen_n_q      <= 1'b1;
      up_ready_n_q <= 1'b1;
      wdat_q       <= '0;
    end
    else
    begin
      wen_n_q      <= !hold_d;
      up_ready_n_q <= hold_d;
      // Lanes side by side form the wide word; see RULE7 and RULE6
      if (up_take)
        wdat_q <= up_data;
    end
  end

  // Read side: shared enable and delivered word
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ren_n_q    <= 1'b1;
      dn_valid_q <= 1'b0;
      dn_data_q  <= '0;
    end
    else
    begin
      // Ask only while the delivery slot will be free
      ren_n_q    <= dnv_d;
      dn_valid_q <= dnv_d;
      if (pop)
        dn_data_q <= link.read_data_bus;
    end
  end

  // Strap levels from reset; single rate held, fall-through follows FIRST_WORD_FALL_THROUGH after reset; see RULE10 and RULE11
  logic first_word_fall_through_q;     // Fall-through strap level
  logic sdr_q;      // Single rate strap level

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      first_word_fall_through_q <= STRAP_FIRST_WORD_FALL_THROUGH;
      sdr_q  <= STRAP_SDR;
    end
    else
    begin
      first_word_fall_through_q <= FIRST_WORD_FALL_THROUGH;
      sdr_q  <= STRAP_SDR;
    end
  end

  assign link.write_en_n              = wen_n_q;
  assign link.write_data_bus          = wdat_q;
  assign link.read_en_n               = ren_n_q;
  assign link.first_word_fall_through = first_word_fall_through_q;
  assign link.single_rate_mode        = sdr_q;

  //////////////////////////////////////////////////////////////////////////////
  // Latency watch

  logic             fill_run_q;    // Waiting for the first word
  logic             drain_run_q;   // Waiting for the first slot
  logic [CNT_W-1:0] fill_cnt_q;    // Cycles since the write
  logic [CNT_W-1:0] drain_cnt_q;   // Cycles since the read

  // A write into an empty chain starts the ripple; see RULE12
  wire fill_start  = acc && (level_q == '0);
  // A read from a full chain starts the bubble; see RULE17
  wire drain_start = pop && (level_q == LVL_W'(CAPACITY));
  wire fill_over   = fill_run_q && !word_all
                     && (fill_cnt_q >= CNT_W'(FILL_BUDGET));
  wire drain_over  = drain_run_q && !room_all
                     && (drain_cnt_q >= CNT_W'(DRAIN_BUDGET));

  // Counters stop on arrival; late flags stay set until reset
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      level_q      <= '0;
      fill_run_q   <= 1'b0;
      drain_run_q  <= 1'b0;
      fill_cnt_q   <= '0;
      drain_cnt_q  <= '0;
      fill_late_q  <= 1'b0;
      drain_late_q <= 1'b0;
    end
    else
    begin
      level_q <= level_d;
      // Fill watch
      if (fill_start)
      begin
        fill_run_q <= 1'b1;
        fill_cnt_q <= '0;
      end
      else if (fill_run_q && (word_all || fill_over))
        fill_run_q <= 1'b0;
      else if (fill_run_q)
        fill_cnt_q <= fill_cnt_q + 1'b1;
      // Drain watch
      if (drain_start)
      begin
        drain_run_q <= 1'b1;
        drain_cnt_q <= '0;
      end
      else if (drain_run_q && (room_all || drain_over))
        drain_run_q <= 1'b0;
      else if (drain_run_q)
        drain_cnt_q <= drain_cnt_q + 1'b1;
      // Sticky lateness
      if (fill_over)
        fill_late_q <= 1'b1;
      if (drain_over)
        drain_late_q <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// file: hdl/fwx_dummy_unused.sv
// Holds no design code; every module lives in a file of its own
`default_nettype none
`default_nettype wire

// file: tb/fwx_link_checker.sv
// Link checker for the expanded FIFO chain and its host end
`default_nettype none

module fwx_link_checker
  import fwx_pkg::*;
#(
  parameter int LANE_N      = LANES,
  parameter int WIDTH       = DATA_W,
  parameter int STAGE_N     = STAGES,
  parameter int DEPTH_WORDS = DEPTH
)(
  // Clock and reset
  input wire logic                    ref_clk,
  input wire logic                    rst_b,
  // Write side
  input wire logic [LANE_N*WIDTH-1:0] write_data_bus,
  input wire logic                    write_en_n,
  input wire logic [LANE_N-1:0]       input_ready_n,
  // Read side
  input wire logic [LANE_N*WIDTH-1:0] read_data_bus,
  input wire logic                    read_en_n,
  input wire logic [LANE_N-1:0]       output_ready_n,
  // Straps
  input wire logic                    first_word_fall_through,
  input wire logic                    single_rate_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CAP = STAGE_N * (DEPTH_WORDS + 1);  // Stage memory plus output reg
  logic        wr_take;  // Word enters the head
  logic        rd_take;  // Word leaves the tail
  logic [15:0] occ_q;    // Words inside the chain
  logic [15:0] occ_d;
  assign wr_take = !write_en_n && (input_ready_n == '0);
  assign rd_take = !read_en_n && (output_ready_n == '0);
  assign occ_d   = occ_q + 16'(wr_take) - 16'(rd_take);
  // Count from the link only, so a stuck internal counter cannot hide
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      occ_q <= 16'h0000;
    else
      occ_q <= occ_d;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  // Ripple and bubble waits; one spare edge for where the flop lands
  sequence s_fill_wait;
    (|output_ready_n) [*6] ##[1:2] (output_ready_n == '0);
  endsequence
  sequence s_bubble_wait;
    (|input_ready_n) [*4] ##[1:2] (input_ready_n == '0);
  endsequence
  a_fill_ripple_time: assert property (wr_take && occ_q == 16'h0000 |=> s_fill_wait)
    else $error("first word reached the tail at the wrong time");
  a_drain_bubble_time: assert property (rd_take && occ_q == 16'(CAP) |=> s_bubble_wait)
    else $error("free slot reached the head at the wrong time");
  a_word_holds_out: assert property (output_ready_n == '0 && read_en_n
    |=> output_ready_n == '0 && $stable(read_data_bus))
    else $error("tail word moved without a read");
  a_empty_no_word: assert property (occ_q == 16'h0000 |-> &output_ready_n)
    else $error("tail flagged a word in an empty chain");
  a_no_overfill: assert property (wr_take |-> occ_q < 16'(CAP))
    else $error("write taken beyond capacity");
  a_full_refuses: assert property (occ_q == 16'(CAP) |-> &input_ready_n)
    else $error("head offered room while full");
  a_lane_in_skew: assert property (input_ready_n[0] != input_ready_n[LANE_N-1]
    |=> input_ready_n[0] == input_ready_n[LANE_N-1])
    else $error("lane room flags apart for two cycles");
  a_lane_out_skew: assert property (output_ready_n[0] != output_ready_n[LANE_N-1]
    |=> output_ready_n[0] == output_ready_n[LANE_N-1])
    else $error("lane word flags apart for two cycles");
  a_straps_set: assert property (first_word_fall_through && single_rate_mode)
    else $error("chain strapped out of fall-through single rate");
  a_write_holds: assert property (!write_en_n && (|input_ready_n)
    |=> !write_en_n && $stable(write_data_bus))
    else $error("refused write dropped or changed");
endmodule

`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench: host end and chain joined by the link
`default_nettype none

module testbench
  import fwx_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int W = LANES * DATA_W;           // Wide word
  localparam int LW = $clog2(STAGES * (DEPTH + 1) + 1);  // Host level width
  logic         ref_clk      = 1'b0;
  logic         rst_b        = 1'b0;
  logic [W-1:0] up_data      = '0;
  logic         up_valid     = 1'b0;
  logic         dn_ready     = 1'b0;
  logic         up_ready_n_q;
  logic [W-1:0] dn_data_q;
  logic         dn_valid_q;
  logic         fill_late_q;
  logic         drain_late_q;
  logic         cfg_ok_q;
  logic         mode_error_q;
  logic [LW-1:0] level_q;
  logic [W-1:0] sb_q[$];                       // Words owed to the reader
  logic [W-1:0] corner[4] = '{40'h00_0000_0000, 40'hff_ffff_ffff,
                              40'hff_fff0_0000, 40'h00_000f_ffff};
  logic [63:0]  rnd;
  int           to_send   = 0;                 // Words still to offer
  int           rd_pct    = 0;                 // Reader acceptance odds
  int           n_corner  = 4;                 // Next lane pattern to use
  int           wr_cnt    = 0;                 // Link writes taken
  int           rd_cnt    = 0;                 // Link reads taken
  int           cyc       = 0;
  int           t0        = 0;
  int           bad_count = 0;
  int           cmp_count = 0;

  always #2.5 ref_clk = ~ref_clk;

  fwx_link_if i_fwx_link_if ();
  fwx_chain i_fwx_chain (.ref_clk(ref_clk), .rst_b(rst_b), .link(i_fwx_link_if),
    .cfg_ok_q(cfg_ok_q), .mode_error_q(mode_error_q));
  fwx_host i_fwx_host (.ref_clk(ref_clk), .rst_b(rst_b), .link(i_fwx_link_if),
    .up_data(up_data), .up_valid(up_valid), .up_ready_n_q(up_ready_n_q),
    .dn_data_q(dn_data_q), .dn_valid_q(dn_valid_q), .dn_ready(dn_ready),
    .level_q(level_q), .fill_late_q(fill_late_q), .drain_late_q(drain_late_q));
  fwx_link_checker i_fwx_link_checker (.ref_clk(ref_clk), .rst_b(rst_b),
    .write_data_bus(i_fwx_link_if.write_data_bus), .write_en_n(i_fwx_link_if.write_en_n),
    .input_ready_n(i_fwx_link_if.input_ready_n), .read_data_bus(i_fwx_link_if.read_data_bus),
    .read_en_n(i_fwx_link_if.read_en_n), .output_ready_n(i_fwx_link_if.output_ready_n),
    .first_word_fall_through(i_fwx_link_if.first_word_fall_through),
    .single_rate_mode(i_fwx_link_if.single_rate_mode));

  ////////////////////////////////////////////////////////////////////////////
  // Chain capacity: each stage adds its output register to its memory
  function automatic int cap_words();
    return STAGES * (DEPTH + 1);
  endfunction

  task automatic chk_word(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic chk_flag(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s exp %b got %b", what, exp, got);
    end
  endtask

  task automatic chk_count(input string what, input int exp, input int got);
    cmp_count++;
    if (got != exp)
    begin
      bad_count++;
      $display("BAD %s exp %0d got %0d", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Offer n more words, then wait (bounded) until all have come out
  task automatic run(input int n, input int lim);
    int i;
    to_send += n;
    for (i = 0; i < lim && (to_send > 0 || sb_q.size() > 0); i++)
      @(negedge ref_clk);
    chk_count("words left", 0, to_send + sb_q.size());
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Link counts, scoreboard and hang guard, sampled before NBAs land
  always @(posedge ref_clk)
  begin
    cyc++;
    if (rst_b && !i_fwx_link_if.write_en_n && i_fwx_link_if.input_ready_n == '0)
      wr_cnt++;
    if (rst_b && !i_fwx_link_if.read_en_n && i_fwx_link_if.output_ready_n == '0)
      rd_cnt++;
    if (dn_valid_q && dn_ready)
      chk_word("dn_data", sb_q.pop_front(), dn_data_q);
    // Hang guard last, so nothing in this process follows the verdict
    if (cyc == 20000)
    begin
      bad_count++;
      test_done();
    end
  end

  // Writer: hold a word until taken; lane corner patterns go first
  always @(posedge ref_clk)
  begin
    if (rst_b && up_valid && !up_ready_n_q)
    begin
      sb_q.push_back(up_data);
      to_send--;
    end
    // Reset drops any offered word, so none leaks past a mid-run reset
    if (!rst_b || !up_valid || !up_ready_n_q)
    begin
      rnd = {$urandom(), $urandom()};
      up_valid <= rst_b && to_send > 0;
      up_data  <= (n_corner < 4) ? corner[n_corner] : rnd[W-1:0];
      if (to_send > 0 && n_corner < 4)
        n_corner++;
    end
  end

  // Reader stalls at random
  always @(posedge ref_clk)
    dn_ready <= ($urandom_range(99) < rd_pct);

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h7ab3_5d00));
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(negedge ref_clk);
    chk_flag("cfg_ok", 1'b1, cfg_ok_q);
    chk_flag("mode_error", 1'b0, mode_error_q);
    // Lone word ripples down an empty chain
    rd_pct = 100;
    run(1, 200);
    // Fill with the reader stalled, then drain with stalls
    rd_pct = 0;
    to_send = 40;
    repeat (150) @(negedge ref_clk);
    chk_count("chain words", cap_words(), wr_cnt - rd_cnt);
    chk_flag("head full", 1'b1, &i_fwx_link_if.input_ready_n);
    chk_count("host level", cap_words(), level_q);
    rd_pct = 50;
    run(0, 3000);
    chk_flag("drain late", 1'b0, drain_late_q);
    chk_flag("fill late", 1'b0, fill_late_q);
    // Lane corners then random words with stalls
    n_corner = 0;
    rd_pct = 70;
    run(300, 5000);
    // Steady stream: no ripple delay after the first word
    rd_pct = 100;
    t0 = cyc;
    run(100, 1000);
    chk_flag("steady rate", 1'b1, (cyc - t0) <= 240);
    // Reset in mid-fill empties the chain
    rd_pct = 0;
    to_send = 20;
    repeat (30) @(posedge ref_clk);
    rst_b <= 1'b0;
    // Writer and reader are idle in reset, so the books clear safely here
    repeat (3) @(posedge ref_clk);
    to_send = 0;
    sb_q.delete();
    rst_b <= 1'b1;
    repeat (4) @(negedge ref_clk);
    chk_flag("cfg_ok again", 1'b1, cfg_ok_q);
    rd_pct = 100;
    run(5, 300);
    test_done();
  end
endmodule

`default_nettype wire
